// ===== logic/sfid_dev.sv
// sfid_dev: identification-read responder of the flash command decoder
// assumes: link logic runs on the serial clock; chip enable high resets the frame
// assumes: clk_en and busy_in are levels from core_clk logic
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - opcodes 90h and abh both decode as id
// - full 24-bit address, msb first, precedes data
// - address zero manufacturer, address one device
// - output alternates bytes, starting from address
// - only chip enable rising ends output
// - host uses this command for identification
// - ignore command while internal cycle busy
module sfid_dev
  import sfid_pkg::*;
#(
  parameter logic [7:0] MFR_ID = SFID_MFR_ID_DFLT,
  parameter logic [7:0] DEV_ID = SFID_DEV_ID_DFLT
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic busy_in,
  output var  logic id_active,
  sfid_if.dev       lnk
);

  // IGN swallows the rest of a frame; only a deselect leaves it
  typedef enum logic [1:0] {SFID_ST_OPC, SFID_ST_ADDR, SFID_ST_DATA, SFID_ST_IGN} sfid_st_type;

  //////////////////////////////////////////////////////////////////////////
  // core-side levels into the link domain; frame reset is chip enable itself
  // a deselect resets every link flop, so no state leaks into the next frame
  logic frm_rst;
  logic busy_lnk;
  logic lnk_en;
  assign frm_rst = rst | lnk.ce_n;

  // busy is only looked at on the 8th rise, long after the sync has settled
  // both syncs run free of the enable so that they can never latch up
  sfid_sync2 #(
    .RST_VAL (1'b0)
  ) busy_sync_i (
    .clk  (lnk.sck),
    .arst (frm_rst),
    .en   (1'b1),
    .d    (busy_in),
    .q    (busy_lnk)
  );

  // enable resets high: a frame opened while frozen still runs two rises
  // before the freeze takes hold; the host is expected to stop clocking too
  sfid_sync2 #(
    .RST_VAL (1'b1)
  ) en_sync_i (
    .clk  (lnk.sck),
    .arst (frm_rst),
    .en   (1'b1),
    .d    (clk_en),
    .q    (lnk_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // rising-edge input side
  // cnt counts bits inside the current field and wraps at each field end;
  // the opcode is judged on sh_nxt, so it is decided on its own 8th rise
  // rather than one rise later, when the address would already be shifting
  sfid_st_type st_r,  st_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [7:0]  sh_r,  sh_nxt;
  logic        sel_r, sel_nxt;
  logic        load_r, load_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r + SFID_CNT_ONE;
    sh_nxt   = {sh_r[6:0], lnk.si};
    sel_nxt  = sel_r;
    load_nxt = 1'b0;
    case (st_r)
      SFID_ST_OPC: begin
        if (cnt_r == 6'(SFID_OPC_BITS - 1)) begin
          cnt_nxt = SFID_CNT_ZERO;
          // a busy-time opcode parks the frame; the running cycle never sees it
          if (busy_lnk)
            st_nxt = SFID_ST_IGN;
          else if (sh_nxt == SFID_OPC_ID_A || sh_nxt == SFID_OPC_ID_B)
            st_nxt = SFID_ST_ADDR;
          else
            st_nxt = SFID_ST_IGN;
        end
      end
      SFID_ST_ADDR: begin
        if (cnt_r == 6'(SFID_ADDR_BITS - 1)) begin
          cnt_nxt  = SFID_CNT_ZERO;
          // the last address bit arrives on this rise and picks the first byte
          sel_nxt  = lnk.si;
          load_nxt = 1'b1;
          st_nxt   = SFID_ST_DATA;
        end
      end
      SFID_ST_DATA: begin
        if (cnt_r == 6'(SFID_BYTE_BITS - 1)) begin
          cnt_nxt  = SFID_CNT_ZERO;
          // flips at every byte boundary for as long as the host keeps clocking
          sel_nxt  = ~sel_r;
          load_nxt = 1'b1;
        end
      end
      SFID_ST_IGN: cnt_nxt = cnt_r;
      default:     st_nxt = SFID_ST_IGN;
    endcase
  end

  always_ff @(posedge lnk.sck or posedge frm_rst) begin
    if (frm_rst) begin
      st_r   <= SFID_ST_OPC;
      cnt_r  <= SFID_CNT_ZERO;
      sh_r   <= 8'h00;
      sel_r  <= 1'b0;
      load_r <= 1'b0;
    end else if (lnk_en) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      sel_r  <= sel_nxt;
      load_r <= load_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // falling-edge output side
  // runs half a period behind the input side: a byte chosen on a rise is
  // launched on the next fall, which leaves the host a whole low phase of
  // setup before its sampling rise
  logic [7:0] out_r, out_nxt;
  logic       oe_r,  oe_nxt;

  always_comb begin
    out_nxt = {out_r[6:0], 1'b0};
    oe_nxt  = oe_r;
    if (load_r) begin
      out_nxt = sel_r ? DEV_ID : MFR_ID;
      oe_nxt  = 1'b1;
    end
  end

  always_ff @(negedge lnk.sck or posedge frm_rst) begin
    if (frm_rst) begin
      out_r <= 8'h00;
      oe_r  <= 1'b0;
    end else if (lnk_en) begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // so_oe only drops with the deselect; there is no high-impedance state here
  assign lnk.so    = out_r[7];
  assign lnk.so_oe = oe_r;

  //////////////////////////////////////////////////////////////////////////
  // status to core domain; lags the link by two core cycles
  // core side freezes with clk_en; the link side freezes through en_sync_i
  sfid_sync2 #(
    .RST_VAL (1'b0)
  ) act_sync_i (
    .clk  (core_clk),
    .arst (rst),
    .en   (clk_en),
    .d    (oe_r),
    .q    (id_active)
  );

endmodule

//////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser shared by both ends; only the second flop is read
// reset value is a parameter so an enable path can come up open
module sfid_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic arst,
  input  wire logic en,
  input  wire logic d,
  output var  logic q
);

  logic s1_r;
  logic s2_r;

  // en freezes both flops; a frozen domain keeps its last sampled level
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
    end else if (en) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule
`default_nettype wire

// ===== logic/sfid_pkg.sv
// sfid_pkg: constants shared by both ends of the identification-read link
// assumes: spi mode 0/3 framing, msb first on both lines
package sfid_pkg;
  localparam logic [7:0]  SFID_OPC_ID_A     = 8'h90;
  localparam logic [7:0]  SFID_OPC_ID_B     = 8'hab;
  localparam int          SFID_OPC_BITS     = 8;
  localparam int          SFID_ADDR_BITS    = 24;
  localparam int          SFID_BYTE_BITS    = 8;
  localparam logic [23:0] SFID_ADDR_MFR     = 24'h000000;
  localparam logic [23:0] SFID_ADDR_DEV     = 24'h000001;
  // identity bytes are arbitrary neutral values
  localparam logic [7:0]  SFID_MFR_ID_DFLT  = 8'h5a;
  localparam logic [7:0]  SFID_DEV_ID_DFLT  = 8'h3c;
  localparam int          SFID_SCK_HALF_DIV = 4;
  localparam logic [5:0]  SFID_CNT_ZERO     = 6'h00;
  localparam logic [5:0]  SFID_CNT_ONE      = 6'h01;
endpackage

// ===== logic/sfid_if.sv
// sfid_if: serial wires between host and device
// assumes: the host drives clock, chip enable and serial input
`timescale 1ns/100ps
`default_nettype none
interface sfid_if;
  logic sck;
  logic ce_n;
  logic si;
  logic so;
  logic so_oe;
  modport host (output sck, output ce_n, output si, input so, input so_oe);
  modport dev  (input sck, input ce_n, input si, output so, output so_oe);
endinterface
`default_nettype wire

// ===== logic/sfid_host.sv
// sfid_host: spi host issuing the identification read
// assumes: link clock derived here by a divider of core_clk
`timescale 1ns/100ps
`default_nettype none
module sfid_host
  import sfid_pkg::*;
#(
  parameter int HALF_DIV = SFID_SCK_HALF_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        opc_sel,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  nbytes,
  output logic             busy,
  output logic             byte_vld,
  output logic [7:0]       byte_dat,
  sfid_if.host             lnk
);

  typedef enum logic [1:0] {SFH_IDLE, SFH_SEND, SFH_RECV, SFH_END} sfh_st_type;

  sfh_st_type  st_r, st_nxt;
  logic [7:0]  div_r, div_nxt;
  logic        sck_r, sck_nxt;
  logic        ce_n_r, ce_n_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic [7:0]  left_r, left_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic        vld_r, vld_nxt;
  logic [7:0]  dat_r, dat_nxt;
  logic        busy_r, busy_nxt;
  logic        so_s2;
  logic        tick;

  assign tick = (div_r == 8'(HALF_DIV - 1));

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = tick ? 8'h00 : div_r + 8'h01;
    sck_nxt  = sck_r;
    ce_n_nxt = ce_n_r;
    tx_nxt   = tx_r;
    bit_nxt  = bit_r;
    left_nxt = left_r;
    rx_nxt   = rx_r;
    vld_nxt  = 1'b0;
    dat_nxt  = dat_r;
    case (st_r)
      SFH_IDLE: begin
        div_nxt = 8'h00;
        if (start) begin
          tx_nxt   = {opc_sel ? SFID_OPC_ID_B : SFID_OPC_ID_A, addr};
          bit_nxt  = SFID_CNT_ZERO;
          left_nxt = nbytes;
          ce_n_nxt = 1'b0;
          st_nxt   = SFH_SEND;
        end
      end
      SFH_SEND, SFH_RECV: if (tick) begin
        sck_nxt = ~sck_r;
        if (sck_r) begin // falling edge: advance data
          if (st_r == SFH_SEND) begin
            tx_nxt = {tx_r[30:0], 1'b0};
            if (bit_r == 6'(SFID_OPC_BITS + SFID_ADDR_BITS - 1)) begin
              bit_nxt = SFID_CNT_ZERO;
              st_nxt  = (left_r == 8'h00) ? SFH_END : SFH_RECV;
            end else
              bit_nxt = bit_r + SFID_CNT_ONE;
          end
        end else if (st_r == SFH_RECV) begin
          rx_nxt = {rx_r[6:0], so_s2};
          if (bit_r == 6'(SFID_BYTE_BITS - 1)) begin
            bit_nxt  = SFID_CNT_ZERO;
            vld_nxt  = 1'b1;
            dat_nxt  = {rx_r[6:0], so_s2};
            left_nxt = left_r - 8'h01;
            if (left_r == 8'h01)
              st_nxt = SFH_END;
          end else
            bit_nxt = bit_r + SFID_CNT_ONE;
        end
      end
      SFH_END: if (tick) begin
        sck_nxt  = 1'b0;
        ce_n_nxt = 1'b1;
        st_nxt   = SFH_IDLE;
      end
      default: st_nxt = SFH_IDLE;
    endcase
    busy_nxt = (st_nxt != SFH_IDLE);
  end

  // so is sampled late in the sck-low phase; the synchroniser lag is hidden
  // by a divider of at least four core cycles per half period
  sfid_sync2 #(
    .RST_VAL (1'b0)
  ) so_sync_i (
    .clk  (core_clk),
    .arst (rst),
    .en   (clk_en),
    .d    (lnk.so),
    .q    (so_s2)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r   <= SFH_IDLE;
      div_r  <= 8'h00;
      sck_r  <= 1'b0;
      ce_n_r <= 1'b1;
      tx_r   <= 32'h0000_0000;
      bit_r  <= SFID_CNT_ZERO;
      left_r <= 8'h00;
      rx_r   <= 8'h00;
      vld_r  <= 1'b0;
      dat_r  <= 8'h00;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      sck_r  <= sck_nxt;
      ce_n_r <= ce_n_nxt;
      tx_r   <= tx_nxt;
      bit_r  <= bit_nxt;
      left_r <= left_nxt;
      rx_r   <= rx_nxt;
      vld_r  <= vld_nxt;
      dat_r  <= dat_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign lnk.sck  = sck_r;
  assign lnk.ce_n = ce_n_r;
  assign lnk.si   = tx_r[31];
  assign busy     = busy_r;
  assign byte_vld = vld_r;
  assign byte_dat = dat_r;

endmodule
`default_nettype wire

// ===== test/sfid_sva.sv
// sfid_sva: link wire checks
// assumes: core_clk samples all link wires, sck half period 4
`timescale 1ns/100ps
`default_nettype none
module sfid_sva #(
  parameter logic [7:0] MFR_ID = 8'h00,
  parameter logic [7:0] DEV_ID = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic ce_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic        sck_r, sck_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [31:0] sh_r, sh_nxt;
  // rises of sck seen from core side
  always_comb begin
    sck_nxt = sck;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    if (ce_n) begin
      cnt_nxt = 6'h00;
    end else if (sck && !sck_r && cnt_r != 6'h3f) begin
      cnt_nxt = cnt_r + 6'h01;
      sh_nxt  = {sh_r[30:0], si};
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) {sck_r, cnt_r, sh_r} <= '0;
    else {sck_r, cnt_r, sh_r} <= {sck_nxt, cnt_nxt, sh_nxt};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_oe_ce; so_oe |-> !ce_n; endproperty
  a_oe_ce: assert property (p_oe_ce) else $error("so driven with ce high");
  property p_oe_end; $fell(so_oe) |-> ce_n; endproperty
  a_oe_end: assert property (p_oe_end) else $error("output ended early");
  property p_oe_cnt; $rose(so_oe) |-> cnt_r == 6'h20 && !sck; endproperty
  a_oe_cnt: assert property (p_oe_cnt) else $error("output not after 32 bits");
  property p_opc; $rose(so_oe) |-> sh_r[31:24] inside {8'h90, 8'hab}; endproperty
  a_opc: assert property (p_opc) else $error("output on bad opcode");
  property p_first; $rose(so_oe) |-> so == (sh_r[0] ? DEV_ID[7] : MFR_ID[7]); endproperty
  a_first: assert property (p_first) else $error("wrong first bit");
  property p_so_fall; so_oe && $changed(so) |-> !sck; endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved with sck high");
  property p_si_fall; !ce_n && $changed(si) |-> !sck; endproperty
  a_si_fall: assert property (p_si_fall) else $error("si moved with sck high");
  property p_sck_hi; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
  a_sck_hi: assert property (p_sck_hi) else $error("sck high time");
  property p_ce_sck; $fell(ce_n) |-> !sck; endproperty
  a_ce_sck: assert property (p_ce_sck) else $error("frame opened with sck high");
endmodule
`default_nettype wire

// ===== test/sfid_tb_top.sv
// sfid_tb_top: host and device joined, bytes scored from a queue
// assumes: host divides core_clk to make sck
`timescale 1ns/100ps
`default_nettype none
module sfid_tb_top
  import sfid_pkg::*;
;
  localparam logic [7:0] MFR = 8'ha5; // arbitrary
  localparam logic [7:0] DEV = 8'h96; // arbitrary
  logic        core_clk, rst, start, opc_sel, busy_in, busy, byte_vld, id_active, oe_seen;
  logic [23:0] addr;
  logic [7:0]  nbytes, byte_dat;
  logic [31:0] seed;
  logic [8:0]  e;
  logic [8:0]  exp_q[$];
  int          mismatches, checked;
  sfid_if lnk ();
  sfid_host sfid_host_i (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .start(start),
    .opc_sel(opc_sel), .addr(addr), .nbytes(nbytes), .busy(busy), .byte_vld(byte_vld),
    .byte_dat(byte_dat), .lnk(lnk.host));
  sfid_dev #(.MFR_ID(MFR), .DEV_ID(DEV)) sfid_dev_i (.core_clk(core_clk), .rst(rst),
    .clk_en(1'b1), .busy_in(busy_in), .id_active(id_active), .lnk(lnk.dev));
  sfid_sva #(.MFR_ID(MFR), .DEV_ID(DEV)) sfid_sva_i (.core_clk(core_clk), .rst(rst),
    .sck(lnk.sck), .ce_n(lnk.ce_n), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // refused frames still clock bytes, so their notes carry a skip flag
  task automatic run(input logic sel, input logic [23:0] a, input logic [7:0] n,
                     input logic bsy);
    int k;
    k = 0;
    oe_seen = 1'b0;
    for (int i = 0; i < n; i++) exp_q.push_back({bsy, (a[0] ^ i[0]) ? DEV : MFR});
    @(posedge core_clk);
    opc_sel <= sel;
    addr    <= a;
    nbytes  <= n;
    busy_in <= bsy;
    start   <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    while (k < 3000 && (busy !== 1'b0 || k < 2)) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 3000) begin
      mismatches++;
      end_of_test();
    end
    repeat (30) @(posedge core_clk);
    busy_in <= 1'b0;
    chk("so_oe", {7'h00, oe_seen}, {7'h00, ~bsy});
    chk("left", 8'(exp_q.size()), 8'h00);
    chk("id_idle", {7'h00, id_active}, 8'h00);
  endtask
  always @(negedge core_clk) begin
    if (lnk.so_oe === 1'b1) oe_seen = 1'b1;
    if (byte_vld === 1'b1) begin
      if (exp_q.size() == 0) chk("extra", 8'h01, 8'h00);
      else begin
        e = exp_q.pop_front();
        if (!e[8]) chk("byte", byte_dat, e[7:0]);
        chk("id_active", {7'h00, id_active}, {7'h00, ~e[8]});
      end
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // both opcodes and both start bytes; random upper address bits must not matter
  initial begin
    {rst, start, opc_sel, busy_in, oe_seen} = 5'h10;
    addr = 24'h000000;
    nbytes = 8'h00;
    mismatches = 0;
    checked = 0;
    seed = 32'h0000002f;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      run(i[0], {seed[23:1], i[1]}, (i == 8) ? 8'h00 : {5'h00, seed[26:24]} + 8'h01,
          i == 9);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
